// >>> design/pcs_slot_ctrl.sv
// Card slot status change, reset, type and I/O window control
//
// Summary of operation
// - One shutdown control is shared by both slots.
// - Card reset output is the inverse of the reset control bit.
// - Type bit picks memory card (0) or I/O card (1).
// - Enabled status change sets its flag and raises the interrupt together.
// - Disabled detection never sets its change flag.
// - Clear mode 0: reading status clears flags 3..0 and drops interrupt.
// - Clear mode 1: reads keep flags; writing ones clears those bits.
// - Write-back mode keeps interrupt up until no flag reads as set.
// - Detect flag sets on removal or insertion per both detect pins.
// - No detection in suspend; changes then show after resume.
// - Memory mode ready rising edge sets a sticky ready flag.
// - Ready ignored without card and 1 ms after insertion; reads 0.
// - Battery pins ignored without card, 1 ms after change; read 0.
// - Memory mode good to warning sets sticky warning flag.
// - Dead flag setting clears the warning flag.
// - Memory mode good or warning to dead sets sticky dead flag.
// - I/O mode reads ready, warning and dead flags as 0.
// - Enable bits 3..0 gate detect, ready, warning, dead; off keeps 0.
// - Ready and battery enables act only in memory mode.
// - Window 1 enable maps its range to card I/O cycles.
// - Window 0 enable maps its range to card I/O cycles.
// - Card address is CPU address 15..0 with 25..16 zero.
`timescale 1ns/1ps
module pcs_slot_ctrl
  import pcs_pkg::*;
#(
  parameter int BLANK_CNT = BLANK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdata_r,
  input wire pcs_pins_t cardPins,
  input wire logic hostMemReq,
  input wire logic [25:0] hostAddr,
  output logic card_reset_out_r,
  output logic irqOut_r,
  output logic prog_supply_gate_out_r,
  output logic prog_supply_select_out_r,
  output logic commonShutdown_r,
  output logic ioCardMode_r,
  output logic cardIoCycle_r,
  output logic [1:0] ioWinHit_r,
  output logic [25:0] cardAddr_r
);
  localparam int CNT_W = $clog2(BLANK_CNT + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(BLANK_CNT);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam int NPIN = $bits(pcs_pins_t);
  // Pulled-up pins idle high, suspend idles low: no false edge after reset
  localparam logic [NPIN-1:0] PIN_IDLE = {{(NPIN-1){1'b1}}, 1'b0};

  initial begin
    if (BLANK_CNT < 1) begin
      $error("BLANK_CNT must be at least 1");
    end
  end

  // Pin synchronisers
  logic [NPIN-1:0] pinMeta_r;
  logic [NPIN-1:0] pinSync_r;
  pcs_pins_t pins;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : gSync
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          pinMeta_r[gi] <= PIN_IDLE[gi];
          pinSync_r[gi] <= PIN_IDLE[gi];
        end else begin
          pinMeta_r[gi] <= cardPins[gi];
          pinSync_r[gi] <= pinMeta_r[gi];
        end
      end
    end
  endgenerate

  assign pins = pcs_pins_t'(pinSync_r);

  // Registers
  logic [7:0] power_r;
  logic [7:0] ctrl_r;
  logic [3:0] flags_r;
  logic [3:0] flags_nxt;
  logic [7:0] irqEn_r;
  logic [7:0] winEn_r;
  logic [7:0] global_r;
  logic shutdown_r;
  logic [15:0] winStart_r [2];
  logic [15:0] winStop_r [2];
  logic [7:0] winCtl_r [2];

  logic wrPower;
  logic wrCtrl;
  logic wrStat;
  logic rdStat;
  logic wrIrqEn;
  logic wrWinEn;
  logic wrGlobal;
  logic wrShut;
  logic memMode;
  logic clrMode;

  assign wrPower = regWr && (regAddr == OFF_POWER);
  assign wrCtrl = regWr && (regAddr == OFF_CTRL);
  assign wrStat = regWr && (regAddr == OFF_STAT);
  assign rdStat = regRd && (regAddr == OFF_STAT);
  assign wrIrqEn = regWr && (regAddr == OFF_IRQEN);
  assign wrWinEn = regWr && (regAddr == OFF_WINEN);
  assign wrGlobal = regWr && (regAddr == OFF_GLOBAL);
  assign wrShut = regWr && (regAddr == OFF_SHUTDOWN);
  assign memMode = !ctrl_r[CTRL_TYPE_BIT];
  assign clrMode = global_r[GLOBAL_CLRMODE_BIT];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_r <= RST_BYTE;
      ctrl_r <= RST_BYTE;
      irqEn_r <= RST_BYTE;
      winEn_r <= RST_BYTE;
      global_r <= RST_BYTE;
    end else begin
      if (wrPower) begin
        power_r <= regWdata[7:0];
      end
      if (wrCtrl) begin
        ctrl_r <= regWdata[7:0];
      end
      if (wrIrqEn) begin
        irqEn_r <= regWdata[7:0];
      end
      if (wrWinEn) begin
        winEn_r <= regWdata[7:0];
      end
      if (wrGlobal) begin
        global_r <= regWdata[7:0];
      end
    end
  end

  // Single shutdown bit, shared by both slots
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shutdown_r <= 1'b0;
    end else if (wrShut) begin
      shutdown_r <= regWdata[SHUTDOWN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 2; i++) begin
        winStart_r[i] <= RST_WORD;
        winStop_r[i] <= RST_WORD;
        winCtl_r[i] <= RST_BYTE;
      end
    end else if (regWr) begin
      unique case (regAddr)
        OFF_WIN0_START: winStart_r[0] <= regWdata;
        OFF_WIN0_STOP: winStop_r[0] <= regWdata;
        OFF_WIN0_CTL: winCtl_r[0] <= regWdata[7:0];
        OFF_WIN1_START: winStart_r[1] <= regWdata;
        OFF_WIN1_STOP: winStop_r[1] <= regWdata;
        OFF_WIN1_CTL: winCtl_r[1] <= regWdata[7:0];
        default: ;
      endcase
    end
  end

  // Card presence tracking, frozen while the card clock is stopped
  logic cardIn_r;
  logic insertEvt;
  logic removeEvt;
  logic running;

  assign running = !pins.suspend;
  assign insertEvt = running && !cardIn_r && !pins.card_present_pin_one &&
                     !pins.card_present_pin_two;
  assign removeEvt = running && cardIn_r &&
                     (pins.card_present_pin_one || pins.card_present_pin_two);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cardIn_r <= 1'b0;
    end else if (insertEvt) begin
      cardIn_r <= 1'b1;
    end else if (removeEvt) begin
      cardIn_r <= 1'b0;
    end
  end

  // Settling blank after insertion or removal
  logic [CNT_W-1:0] blankCnt_r;
  logic blank;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blankCnt_r <= CNT_ZERO;
    end else if (insertEvt || removeEvt) begin
      blankCnt_r <= CNT_LOAD;
    end else if (running && (blankCnt_r != CNT_ZERO)) begin
      blankCnt_r <= blankCnt_r - 1'b1;
    end
  end

  assign blank = !cardIn_r || (blankCnt_r != CNT_ZERO);

  // Previous pin levels for edge and state-change detection
  logic readyPrev_r;
  logic battOnePrev_r;
  logic battTwoPrev_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readyPrev_r <= 1'b0;
      battOnePrev_r <= 1'b0;
      battTwoPrev_r <= 1'b0;
    end else if (running) begin
      readyPrev_r <= pins.card_ready_busy_pin;
      battOnePrev_r <= pins.battery_level_pin_one;
      battTwoPrev_r <= pins.battery_level_pin_two;
    end
  end

  logic [3:0] enMask;
  logic [3:0] evt;
  logic [3:0] visible;
  logic sense;

  assign sense = running && memMode && !blank;

  // Ready and battery enables only count in memory mode
  assign enMask = {irqEn_r[3], irqEn_r[2:0] & {3{memMode}}};

  assign evt[STAT_CD_BIT] = (insertEvt || removeEvt) && enMask[STAT_CD_BIT];
  assign evt[STAT_RDY_BIT] = sense && !readyPrev_r && pins.card_ready_busy_pin &&
                             enMask[STAT_RDY_BIT];
  assign evt[STAT_WARN_BIT] = sense && battOnePrev_r && battTwoPrev_r &&
                              pins.battery_level_pin_one && !pins.battery_level_pin_two &&
                              enMask[STAT_WARN_BIT];
  assign evt[STAT_DEAD_BIT] = sense && battOnePrev_r && !pins.battery_level_pin_one &&
                              enMask[STAT_DEAD_BIT];

  // Blanked or I/O-mode ready, warning and dead flags read as zero
  assign visible = {1'b1, {3{memMode && !blank}}};

  always_comb begin
    flags_nxt = flags_r;
    if (rdStat && !clrMode) begin
      flags_nxt = RST_FLAGS;
    end
    if (wrStat && clrMode) begin
      flags_nxt = flags_nxt & ~regWdata[3:0];
    end
    flags_nxt = flags_nxt | evt;
    if (evt[STAT_DEAD_BIT]) begin
      flags_nxt[STAT_WARN_BIT] = 1'b0;
    end
    flags_nxt = flags_nxt & enMask;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_r <= RST_FLAGS;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Interrupt rises with the flag and stays while any flag reads as set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqOut_r <= 1'b0;
    end else begin
      irqOut_r <= |(flags_nxt & visible);
    end
  end

  // Read data, one cycle after the strobe
  logic [DATA_W-1:0] rdMux;

  always_comb begin
    rdMux = RST_WORD;
    unique case (regAddr)
      OFF_POWER: rdMux = {8'h00, power_r};
      OFF_CTRL: rdMux = {8'h00, ctrl_r};
      OFF_STAT: rdMux = {12'h000, flags_r & visible};
      OFF_IRQEN: rdMux = {8'h00, irqEn_r};
      OFF_WINEN: rdMux = {8'h00, winEn_r};
      OFF_WIN0_START: rdMux = winStart_r[0];
      OFF_WIN0_STOP: rdMux = winStop_r[0];
      OFF_WIN0_CTL: rdMux = {8'h00, winCtl_r[0]};
      OFF_WIN1_START: rdMux = winStart_r[1];
      OFF_WIN1_STOP: rdMux = winStop_r[1];
      OFF_WIN1_CTL: rdMux = {8'h00, winCtl_r[1]};
      OFF_GLOBAL: rdMux = {8'h00, global_r};
      OFF_SHUTDOWN: rdMux = {15'h0000, shutdown_r};
      default: rdMux = RST_WORD;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata_r <= RST_WORD;
    end else if (regRd) begin
      regRdata_r <= rdMux;
    end else begin
      regRdata_r <= RST_WORD;
    end
  end

  // Pin-facing control outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      card_reset_out_r <= 1'b1;
      ioCardMode_r <= 1'b0;
      prog_supply_gate_out_r <= 1'b0;
      prog_supply_select_out_r <= 1'b0;
      commonShutdown_r <= 1'b0;
    end else begin
      card_reset_out_r <= !ctrl_r[CTRL_RESET_BIT];
      ioCardMode_r <= ctrl_r[CTRL_TYPE_BIT];
      prog_supply_gate_out_r <= power_r[VPP_HI_BIT];
      prog_supply_select_out_r <= power_r[VPP_LO_BIT];
      commonShutdown_r <= shutdown_r;
    end
  end

  // I/O window decode
  pcs_win_t [1:0] wins;

  assign wins[0] = '{en: winEn_r[WINEN_IO0_BIT], start: winStart_r[0],
                     stop: winStop_r[0]};
  assign wins[1] = '{en: winEn_r[WINEN_IO1_BIT], start: winStart_r[1],
                     stop: winStop_r[1]};

  pcs_window_decode #(
    .NUM_WIN(2)
  ) uDecode (
    .clk(clk),
    .rst_b(rst_b),
    .wins(wins),
    .hostMemReq(hostMemReq),
    .hostAddr(hostAddr),
    .cardIoCycle_r(cardIoCycle_r),
    .winHit_r(ioWinHit_r),
    .cardAddr_r(cardAddr_r)
  );
endmodule

// >>> design/pcs_pkg.sv
// Constants and carrier types for the card slot status and control block
package pcs_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;

  // Register byte addresses
  localparam logic [8:0] OFF_POWER = 9'h008;
  localparam logic [8:0] OFF_CTRL = 9'h00c;
  localparam logic [8:0] OFF_STAT = 9'h010;
  localparam logic [8:0] OFF_IRQEN = 9'h014;
  localparam logic [8:0] OFF_WINEN = 9'h018;
  localparam logic [8:0] OFF_WIN0_START = 9'h020;
  localparam logic [8:0] OFF_WIN0_STOP = 9'h024;
  localparam logic [8:0] OFF_WIN0_CTL = 9'h028;
  localparam logic [8:0] OFF_WIN1_START = 9'h030;
  localparam logic [8:0] OFF_WIN1_STOP = 9'h034;
  localparam logic [8:0] OFF_WIN1_CTL = 9'h038;
  localparam logic [8:0] OFF_GLOBAL = 9'h078;
  localparam logic [8:0] OFF_SHUTDOWN = 9'h10c;

  // Field positions
  localparam int CTRL_RESET_BIT = 6;
  localparam int CTRL_TYPE_BIT = 5;
  localparam int STAT_CD_BIT = 3;
  localparam int STAT_RDY_BIT = 2;
  localparam int STAT_WARN_BIT = 1;
  localparam int STAT_DEAD_BIT = 0;
  localparam int GLOBAL_CLRMODE_BIT = 2;
  localparam int WINEN_IO0_BIT = 6;
  localparam int WINEN_IO1_BIT = 7;
  localparam int SHUTDOWN_BIT = 0;
  localparam int VPP_HI_BIT = 1;
  localparam int VPP_LO_BIT = 0;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [3:0] RST_FLAGS = 4'h0;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int BLANK_TIME_US = 1000;
  localparam int BLANK_CYCLES = BLANK_TIME_US * CLK_MHZ;

  typedef struct packed {
    logic card_present_pin_one;
    logic card_present_pin_two;
    logic card_ready_busy_pin;
    logic battery_level_pin_one;
    logic battery_level_pin_two;
    logic suspend;
  } pcs_pins_t;

  typedef struct packed {
    logic en;
    logic [15:0] start;
    logic [15:0] stop;
  } pcs_win_t;
endpackage

// >>> design/pcs_window_decode.sv
// I/O window decoder turning host memory accesses into card I/O cycles
`timescale 1ns/1ps
module pcs_window_decode
  import pcs_pkg::*;
#(
  parameter int NUM_WIN = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire pcs_win_t [NUM_WIN-1:0] wins,
  input wire logic hostMemReq,
  input wire logic [25:0] hostAddr,
  output logic cardIoCycle_r,
  output logic [NUM_WIN-1:0] winHit_r,
  output logic [25:0] cardAddr_r
);
  initial begin
    if (NUM_WIN < 1) begin
      $error("NUM_WIN must be at least 1");
    end
  end

  logic [NUM_WIN-1:0] hit;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WIN; gi++) begin : gWin
      // Disabled window never produces a card cycle
      assign hit[gi] = hostMemReq && wins[gi].en &&
                       (hostAddr[15:0] >= wins[gi].start) &&
                       (hostAddr[15:0] <= wins[gi].stop);
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cardIoCycle_r <= 1'b0;
      winHit_r <= '0;
    end else begin
      cardIoCycle_r <= |hit;
      winHit_r <= hit;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cardAddr_r <= 26'h0000000;
    end else if (|hit) begin
      cardAddr_r <= {10'h000, hostAddr[15:0]};
    end
  end
endmodule

// >>> testbench/pcs_card_model.sv
// Behavioural card model driving the slot pins
`timescale 1ns/1ps
module pcs_card_model
  import pcs_pkg::*;
(
  input wire logic clk,
  input wire logic present,
  input wire logic rdyLvl,
  input wire logic battOne,
  input wire logic battTwo,
  input wire logic suspend,
  output pcs_pins_t cardPins
);
  // Absent card leaves the pulled-up pins high
  always_ff @(posedge clk) begin
    if (present) begin
      cardPins <= {2'b00, rdyLvl, battOne, battTwo, suspend};
    end else begin
      cardPins <= {5'h1f, suspend};
    end
  end
endmodule

// >>> testbench/pcs_slot_ctrl_sva.sv
// Port assertions for the card slot block
`timescale 1ns/1ps
module pcs_slot_ctrl_sva
  import pcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [DATA_W-1:0] regRdata_r,
  input wire logic hostMemReq,
  input wire logic [25:0] hostAddr,
  input wire logic card_reset_out_r,
  input wire logic irqOut_r,
  input wire logic prog_supply_gate_out_r,
  input wire logic prog_supply_select_out_r,
  input wire logic commonShutdown_r,
  input wire logic ioCardMode_r,
  input wire logic cardIoCycle_r,
  input wire logic [25:0] cardAddr_r
);
  logic clrM_r;
  logic [1:0] winEn_r;
  // Mirrors of clear mode and window enables
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clrM_r <= 1'b0;
      winEn_r <= 2'b00;
    end else if (regWr && regAddr == OFF_GLOBAL) begin
      clrM_r <= regWdata[GLOBAL_CLRMODE_BIT];
    end else if (regWr && regAddr == OFF_WINEN) begin
      winEn_r <= regWdata[7:6];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Pin outputs are registered from their control register: two edges after the write
  a_reset_inverse: assert property (regWr && regAddr == OFF_CTRL |-> ##2
    card_reset_out_r == !$past(regWdata[CTRL_RESET_BIT], 2)) else $error("card reset wrong");
  a_type_select: assert property (regWr && regAddr == OFF_CTRL |-> ##2
    ioCardMode_r == $past(regWdata[CTRL_TYPE_BIT], 2)) else $error("card type wrong");
  a_shutdown_shared: assert property (regWr && regAddr == OFF_SHUTDOWN |-> ##2
    commonShutdown_r == $past(regWdata[SHUTDOWN_BIT], 2)) else $error("shutdown wrong");
  a_supply_follow: assert property (regWr && regAddr == OFF_POWER |-> ##2
    {prog_supply_gate_out_r, prog_supply_select_out_r} == $past(regWdata[1:0], 2))
    else $error("supply outputs wrong");
  a_read_clear: assert property (regRd && regAddr == OFF_STAT && !clrM_r |=>
    !irqOut_r) else $error("read did not drop interrupt");
  a_wb_hold: assert property (regRd && regAddr == OFF_STAT && clrM_r && irqOut_r |=>
    irqOut_r) else $error("interrupt dropped by read in write-back mode");
  a_io_zero: assert property ($past(regRd) && $past(regAddr) == OFF_STAT
    && $past(ioCardMode_r) |-> regRdata_r[2:0] == 3'h0) else $error("io mode flags set");
  a_io_cause: assert property (cardIoCycle_r |-> $past(hostMemReq))
    else $error("card cycle without access");
  a_io_addr: assert property (cardIoCycle_r |->
    cardAddr_r == ($past(hostAddr) & 26'h000ffff)) else $error("card address wrong");
  a_no_window: assert property (hostMemReq && winEn_r == 2'b00 |=> !cardIoCycle_r)
    else $error("cycle with windows off");
endmodule
bind pcs_slot_ctrl pcs_slot_ctrl_sva chk_u (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r),
  .hostMemReq(hostMemReq), .hostAddr(hostAddr), .card_reset_out_r(card_reset_out_r),
  .irqOut_r(irqOut_r), .prog_supply_gate_out_r(prog_supply_gate_out_r),
  .prog_supply_select_out_r(prog_supply_select_out_r), .commonShutdown_r(commonShutdown_r),
  .ioCardMode_r(ioCardMode_r), .cardIoCycle_r(cardIoCycle_r), .cardAddr_r(cardAddr_r));

// >>> testbench/pcs_slot_ctrl_bench.sv
// Self-checking bench for the card slot block
`timescale 1ns/1ps
module pcs_slot_ctrl_bench
  import pcs_pkg::*;
;
  logic clk = 0, rst_b = 0, regWr = 0, regRd = 0, hostMemReq = 0;
  logic [ADDR_W-1:0] regAddr = 0;
  logic [DATA_W-1:0] regWdata = 0, regRdata_r, d;
  logic [25:0] hostAddr = 0, cardAddr;
  logic rstO, irq, gateO, selO, shutO, ioMode, ioCyc;
  logic [1:0] hit, wen;
  logic present = 0, rdyLvl = 1, battOne = 1, battTwo = 1, susp = 0;
  logic [15:0] s0, s1;
  logic [31:0] r32;
  logic [8:0] offs [5] = '{OFF_CTRL, OFF_STAT, OFF_IRQEN, OFF_WINEN, 9'h1f0};
  pcs_pins_t cardPins;
  int seed = 52486, nMismatch = 0, nTests = 0, cyc = 0;
  pcs_card_model card_u (.clk(clk), .present(present), .rdyLvl(rdyLvl), .battOne(battOne),
    .battTwo(battTwo), .suspend(susp), .cardPins(cardPins));
  pcs_slot_ctrl #(.BLANK_CNT(20)) dut_u (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r),
    .cardPins(cardPins), .hostMemReq(hostMemReq), .hostAddr(hostAddr),
    .card_reset_out_r(rstO), .irqOut_r(irq), .prog_supply_gate_out_r(gateO),
    .prog_supply_select_out_r(selO), .commonShutdown_r(shutO), .ioCardMode_r(ioMode),
    .cardIoCycle_r(ioCyc), .ioWinHit_r(hit), .cardAddr_r(cardAddr));
  always #5 clk = ~clk;
  task finish_test();
    $display("mismatches %0d of %0d", nMismatch, nTests);
    if (nMismatch == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      nMismatch = nMismatch + 1;
      $display("FAIL %0t timeout", $time);
      finish_test();
    end
  end
  task chk(input logic [25:0] got, input logic [25:0] exp);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("FAIL %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task chkB(input logic got, input logic exp);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("FAIL %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task wr(input logic [8:0] a, input logic [15:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    // Pin outputs follow their register one edge later
    @(posedge clk);
    #1;
  endtask
  task rd(input logic [8:0] a, input logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk({10'h000, regRdata_r}, {10'h000, e});
  endtask
  task setp(input logic p, input logic r, input logic b1, input logic b2, input logic s);
    @(posedge clk);
    {present, rdyLvl, battOne, battTwo, susp} <= {p, r, b1, b2, s};
    repeat (6) @(posedge clk);
    #1;
  endtask
  function logic [1:0] expHit(input logic [15:0] lo);
    expHit[0] = wen[0] && lo >= s0 && lo <= s0 + 16'h20;
    expHit[1] = wen[1] && lo >= s1 && lo <= s1 + 16'h20;
  endfunction
  task acc(input logic [15:0] lo);
    logic [1:0] eh;
    eh = expHit(lo);
    r32 = $random(seed);
    @(posedge clk);
    hostAddr <= {r32[9:0], lo};
    hostMemReq <= 1'b1;
    @(posedge clk);
    hostMemReq <= 1'b0;
    #1 chkB(ioCyc, |eh);
    chk({24'h0, hit}, {24'h0, eh});
    if (|eh) chk(cardAddr, {10'h000, lo});
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    foreach (offs[i]) rd(offs[i], 16'h0000);
    chkB(rstO, 1'b1);
    $display("test reset done");
    repeat (6) begin
      r32 = $random(seed);
      d = r32[15:0];
      wr(OFF_CTRL, {8'h00, d[7:0]});
      chkB(rstO, ~d[6]);
      chkB(ioMode, d[5]);
      rd(OFF_CTRL, {8'h00, d[7:0]});
    end
    for (int i = 0; i < 4; i++) begin
      wr(OFF_POWER, i[15:0]);
      chk({24'h0, gateO, selO}, i[25:0]);
      wr(OFF_SHUTDOWN, {15'h0, i[0]});
      chkB(shutO, i[0]);
    end
    $display("test control done");
    wr(OFF_CTRL, 16'h0040);
    wr(OFF_IRQEN, 16'h000f);
    setp(1, 0, 1, 1, 0);
    chkB(irq, 1'b1);
    rd(OFF_STAT, 16'h0008);
    chkB(irq, 1'b0);
    setp(1, 1, 1, 1, 0);
    rd(OFF_STAT, 16'h0000);
    repeat (20) @(posedge clk);
    setp(1, 0, 1, 1, 0);
    setp(1, 1, 1, 1, 0);
    setp(1, 0, 1, 1, 0);
    rd(OFF_STAT, 16'h0004);
    wr(OFF_GLOBAL, 16'h0004);
    setp(1, 0, 1, 0, 0);
    rd(OFF_STAT, 16'h0002);
    setp(1, 1, 1, 0, 0);
    rd(OFF_STAT, 16'h0006);
    wr(OFF_STAT, 16'h0004);
    chkB(irq, 1'b1);
    rd(OFF_STAT, 16'h0002);
    setp(1, 1, 1, 1, 0);
    setp(1, 1, 0, 1, 0);
    rd(OFF_STAT, 16'h0001);
    wr(OFF_STAT, 16'h0001);
    chkB(irq, 1'b0);
    $display("test status done");
    wr(OFF_GLOBAL, 16'h0000);
    wr(OFF_IRQEN, 16'h0007);
    setp(0, 1, 1, 1, 0);
    rd(OFF_STAT, 16'h0000);
    wr(OFF_IRQEN, 16'h000f);
    setp(0, 0, 1, 1, 1);
    setp(1, 0, 1, 1, 1);
    rd(OFF_STAT, 16'h0000);
    setp(1, 0, 1, 1, 0);
    rd(OFF_STAT, 16'h0008);
    repeat (25) @(posedge clk);
    wr(OFF_CTRL, 16'h0060);
    setp(1, 1, 1, 1, 0);
    setp(1, 1, 0, 1, 0);
    rd(OFF_STAT, 16'h0000);
    chkB(irq, 1'b0);
    $display("test modes done");
    r32 = $random(seed);
    s0 = {4'h1, r32[11:0]};
    s1 = {4'h8, r32[27:16]};
    wr(OFF_WIN0_START, s0);
    wr(OFF_WIN0_STOP, s0 + 16'h20);
    wr(OFF_WIN1_START, s1);
    wr(OFF_WIN1_STOP, s1 + 16'h20);
    for (int e = 0; e < 4; e++) begin
      wen = e[1:0];
      wr(OFF_WINEN, {8'h00, wen, 6'h00});
      acc(s0);
      acc(s0 + 16'h20);
      acc(s0 + 16'h21);
      acc(s1 - 16'h1);
      acc(s1);
      acc(s1 + 16'h20);
    end
    $display("test windows done");
    finish_test();
  end
endmodule
